/* File: rtl/itm_pkg.sv */
package itm_pkg;

	// ---------------------------------------------------------------
	// operand classes presented by the decoder
	// ---------------------------------------------------------------
	localparam logic [1:0] CLASS_SRC_DOUBLE = 2'h0; // source of double operand
	localparam logic [1:0] CLASS_DST_SINGLE = 2'h1; // read-only single operand dest
	localparam logic [1:0] CLASS_DST_COMP   = 2'h2; // compare_op and bit-test dest

	// ---------------------------------------------------------------
	// timing constants
	// ---------------------------------------------------------------
	localparam int         MICROCYCLE_NS    = 267;  // one microcode cycle
	localparam logic [2:0] PC_REG           = 3'h7; // program counter register field
	localparam logic [3:0] MISS_EXTRA_CYC   = 4'h2; // per main-memory read
	localparam logic [7:0] RESET_CYCLES     = 8'h00;
	localparam logic [1:0] RESET_READS      = 2'h0;

	// general-register address cost, indexed by mode
	localparam logic [3:0] GEN_COST [8] = '{4'h0, 4'h2, 4'h2, 4'h4,
	                                        4'h3, 4'h5, 4'h4, 4'h6};
	// general-register read count, indexed by mode
	localparam logic [1:0] GEN_READS [8] = '{2'h0, 2'h1, 2'h1, 2'h2,
	                                         2'h1, 2'h2, 2'h2, 2'h3};
	// pc source cost for modes 2..5
	localparam logic [3:0] PC_SRC_COST [4] = '{4'h1, 4'h3, 4'h6, 4'h8};
	// pc read-only destination cost for modes 4 and 5
	localparam logic [3:0] PC_DST_COST4 = 4'h7;
	localparam logic [3:0] PC_DST_COST5 = 4'h9;
	localparam logic [1:0] PC_READS4    = 2'h2;
	localparam logic [1:0] PC_READS5    = 2'h3;

endpackage

/* File: rtl/itm_addr_cost.sv */
`timescale 1ns/1ps
`default_nettype none
module itm_addr_cost (
	input  wire logic [1:0] opClass,
	input  wire logic [2:0] addrMode,
	input  wire logic [2:0] regField,
	output logic      [3:0] cost,
	output logic      [1:0] reads
);

	// ---------------------------------------------------------------
	// address calculation table
	// ---------------------------------------------------------------
	logic isPc;
	assign isPc = (regField == itm_pkg::PC_REG);

	// table lookup by class, mode and register
	always_comb begin
		cost  = itm_pkg::GEN_COST[addrMode];
		reads = itm_pkg::GEN_READS[addrMode];
		if (isPc && addrMode >= 3'h2 && addrMode <= 3'h5) begin
			cost = itm_pkg::PC_SRC_COST[2'(addrMode - 3'h2)];
		end
		if (isPc && addrMode == 3'h4) begin
			reads = itm_pkg::PC_READS4;
		end
		if (isPc && addrMode == 3'h5) begin
			reads = itm_pkg::PC_READS5;
		end
		if (opClass != itm_pkg::CLASS_SRC_DOUBLE && isPc && addrMode == 3'h4) begin
			cost = itm_pkg::PC_DST_COST4;
		end
		if (opClass != itm_pkg::CLASS_SRC_DOUBLE && isPc && addrMode == 3'h5) begin
			cost = itm_pkg::PC_DST_COST5;
		end
		if (opClass == itm_pkg::CLASS_DST_COMP && addrMode != 3'h0) begin
			cost = cost + 4'h1;
		end
	end

endmodule
`default_nettype wire

/* File: rtl/itm_timing_model.sv */
`timescale 1ns/1ps
`default_nettype none
module itm_timing_model (
	input  wire logic        core_clk,
	input  wire logic        rstn,
	input  wire logic        syncClear,
	input  wire logic        opValid,
	input  wire logic [1:0]  opClass,
	input  wire logic [2:0]  addrMode,
	input  wire logic [2:0]  regField,
	input  wire logic        mainMemory,
	input  wire logic        writeFlag,
	input  wire logic [3:0]  writeCycles,
	input  wire logic [5:0]  execMinCycles,
	input  wire logic [5:0]  execMaxCycles,
	output logic      [3:0]  addrCycles,
	output logic      [1:0]  addrReads,
	output logic      [7:0]  totalMinCycles,
	output logic      [7:0]  totalMaxCycles,
	output logic      [16:0] totalMinNs,
	output logic      [16:0] totalMaxNs,
	output logic             lowerBound
);

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// cycles to nanoseconds
	function automatic logic [16:0] cyclesToNs(input logic [7:0] cyc);
		cyclesToNs = 17'(cyc * itm_pkg::MICROCYCLE_NS);
	endfunction

	// total of exec part plus operand part
	function automatic logic [7:0] sumCycles(input logic [5:0] exec,
	                                         input logic [7:0] operand);
		sumCycles = 8'({2'h0, exec} + operand);
	endfunction

	// ---------------------------------------------------------------
	// operand cost
	// ---------------------------------------------------------------
	logic [3:0] tabCost;
	logic [1:0] tabReads;
	logic [7:0] operandCycles;
	logic [7:0] missCycles;
	logic [7:0] next_totalMin;
	logic [7:0] next_totalMax;

	itm_addr_cost u_cost (
		.opClass  (opClass),
		.addrMode (addrMode),
		.regField (regField),
		.cost     (tabCost),
		.reads    (tabReads)
	);

	// miss penalty and write time on top of the table entry
	assign missCycles    = mainMemory ? 8'(tabReads * itm_pkg::MISS_EXTRA_CYC) : 8'h00;
	assign operandCycles = 8'({4'h0, tabCost} + missCycles
	                       + (writeFlag ? {4'h0, writeCycles} : 8'h00));
	assign next_totalMin = sumCycles(execMinCycles, operandCycles);
	assign next_totalMax = sumCycles(execMaxCycles, operandCycles);

	// ---------------------------------------------------------------
	// output registers
	// ---------------------------------------------------------------
	// address cost and read count
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			addrCycles <= 4'h0;
			addrReads  <= itm_pkg::RESET_READS;
		end else if (syncClear) begin
			addrCycles <= 4'h0;
			addrReads  <= itm_pkg::RESET_READS;
		end else if (opValid) begin
			addrCycles <= tabCost;
			addrReads  <= tabReads;
		end
	end

	// total range in cycles and nanoseconds
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			totalMinCycles <= itm_pkg::RESET_CYCLES;
			totalMaxCycles <= itm_pkg::RESET_CYCLES;
			totalMinNs     <= 17'h00000;
			totalMaxNs     <= 17'h00000;
			lowerBound     <= 1'b0;
		end else if (syncClear) begin
			totalMinCycles <= itm_pkg::RESET_CYCLES;
			totalMaxCycles <= itm_pkg::RESET_CYCLES;
			totalMinNs     <= 17'h00000;
			totalMaxNs     <= 17'h00000;
			lowerBound     <= 1'b0;
		end else if (opValid) begin
			totalMinCycles <= next_totalMin;
			totalMaxCycles <= next_totalMax;
			totalMinNs     <= cyclesToNs(next_totalMin);
			totalMaxNs     <= cyclesToNs(next_totalMax);
			lowerBound     <= writeFlag;
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	sequence s_req(logic [1:0] cls, logic [2:0] md, logic [2:0] rg);
		opValid && !syncClear && opClass == cls && addrMode == md && regField == rg;
	endsequence

	a_reg_mode_zero: assert property (
		opValid && !syncClear && addrMode == 3'h0 |=> addrCycles == 4'h0 && addrReads == 2'h0)
		else $error("register mode must cost nothing");
	a_gen_src_mode3: assert property (
		s_req(itm_pkg::CLASS_SRC_DOUBLE, 3'h3, 3'h1) |=> addrCycles == 4'h4 && addrReads == 2'h2)
		else $error("source mode 3 cost wrong");
	a_pc_src_mode5: assert property (
		s_req(itm_pkg::CLASS_SRC_DOUBLE, 3'h5, 3'h7) |=> addrCycles == 4'h8 && addrReads == 2'h3)
		else $error("pc source mode 5 cost wrong");
	a_pc_dst_mode4: assert property (
		s_req(itm_pkg::CLASS_DST_SINGLE, 3'h4, 3'h7) |=> addrCycles == 4'h7 && addrReads == 2'h2)
		else $error("pc destination mode 4 cost wrong");
	a_cmp_pc_mode5: assert property (
		s_req(itm_pkg::CLASS_DST_COMP, 3'h5, 3'h7) |=> addrCycles == 4'ha && addrReads == 2'h3)
		else $error("compare pc mode 5 cost wrong");
	a_ns_scale: assert property (
		totalMinNs == 17'(totalMinCycles * 267) && totalMaxNs == 17'(totalMaxCycles * 267))
		else $error("nanosecond time not cycles times 267");
	a_range_order: assert property (
		opValid && !syncClear && execMinCycles <= execMaxCycles |=> totalMinCycles <= totalMaxCycles)
		else $error("minimum exceeds maximum");
	a_total_sum: assert property (
		opValid && !syncClear && !mainMemory && !writeFlag
		|=> totalMinCycles == {2'h0, $past(execMinCycles)} + {4'h0, addrCycles})
		else $error("total is not exec plus address time");
	a_miss_extra: assert property (
		opValid && !syncClear && mainMemory && !writeFlag
		|=> totalMinCycles == 8'($past(execMinCycles) + addrCycles + addrReads * 2))
		else $error("main memory penalty missing");
	a_write_bound: assert property (
		opValid && !syncClear && writeFlag |=> lowerBound)
		else $error("write entry not marked lower bound");
	a_sync_clear: assert property (
		syncClear |=> addrCycles == 4'h0 && addrReads == 2'h0 && totalMaxCycles == 8'h00
		              && !lowerBound)
		else $error("synchronous clear left outputs set");
	a_hold_idle: assert property (
		!opValid && !syncClear |=> $stable(totalMinCycles) && $stable(addrCycles))
		else $error("outputs changed without a request");

	// ---------------------------------------------------------------
	// general-register source table
	// ---------------------------------------------------------------
	// one mode per check, register 0 stands for any general register
	a_gen_src_mode1: assert property (
		s_req(itm_pkg::CLASS_SRC_DOUBLE, 3'h1, 3'h0) |=> addrCycles == 4'h2 && addrReads == 2'h1)
		else $error("source mode 1 cost wrong");
	a_gen_src_mode2: assert property (
		s_req(itm_pkg::CLASS_SRC_DOUBLE, 3'h2, 3'h0) |=> addrCycles == 4'h2 && addrReads == 2'h1)
		else $error("source mode 2 cost wrong");
	a_gen_src_mode4: assert property (
		s_req(itm_pkg::CLASS_SRC_DOUBLE, 3'h4, 3'h0) |=> addrCycles == 4'h3 && addrReads == 2'h1)
		else $error("source mode 4 cost wrong");
	a_gen_src_mode5: assert property (
		s_req(itm_pkg::CLASS_SRC_DOUBLE, 3'h5, 3'h0) |=> addrCycles == 4'h5 && addrReads == 2'h2)
		else $error("source mode 5 cost wrong");
	a_gen_src_mode6: assert property (
		s_req(itm_pkg::CLASS_SRC_DOUBLE, 3'h6, 3'h0) |=> addrCycles == 4'h4 && addrReads == 2'h2)
		else $error("source mode 6 cost wrong");
	a_gen_src_mode7: assert property (
		s_req(itm_pkg::CLASS_SRC_DOUBLE, 3'h7, 3'h0) |=> addrCycles == 4'h6 && addrReads == 2'h3)
		else $error("source mode 7 cost wrong");

	// ---------------------------------------------------------------
	// program counter source table
	// ---------------------------------------------------------------
	// pc modes 2 to 5 differ, modes 6 and 7 fall back to general cost
	a_pc_src_mode2: assert property (
		s_req(itm_pkg::CLASS_SRC_DOUBLE, 3'h2, 3'h7) |=> addrCycles == 4'h1 && addrReads == 2'h1)
		else $error("pc source mode 2 cost wrong");
	a_pc_src_mode3: assert property (
		s_req(itm_pkg::CLASS_SRC_DOUBLE, 3'h3, 3'h7) |=> addrCycles == 4'h3 && addrReads == 2'h2)
		else $error("pc source mode 3 cost wrong");
	a_pc_src_mode4: assert property (
		s_req(itm_pkg::CLASS_SRC_DOUBLE, 3'h4, 3'h7) |=> addrCycles == 4'h6 && addrReads == 2'h2)
		else $error("pc source mode 4 cost wrong");
	a_pc_src_mode6: assert property (
		s_req(itm_pkg::CLASS_SRC_DOUBLE, 3'h6, 3'h7) |=> addrCycles == 4'h4 && addrReads == 2'h2)
		else $error("pc source mode 6 cost wrong");

	// ---------------------------------------------------------------
	// read-only single operand destination
	// ---------------------------------------------------------------
	// only pc modes 4 and 5 part from the source table
	a_pc_dst_mode5: assert property (
		s_req(itm_pkg::CLASS_DST_SINGLE, 3'h5, 3'h7) |=> addrCycles == 4'h9 && addrReads == 2'h3)
		else $error("pc destination mode 5 cost wrong");
	a_dst_gen_mode3: assert property (
		s_req(itm_pkg::CLASS_DST_SINGLE, 3'h3, 3'h0) |=> addrCycles == 4'h4 && addrReads == 2'h2)
		else $error("destination mode 3 cost wrong");

	// ---------------------------------------------------------------
	// compare and bit-test destination
	// ---------------------------------------------------------------
	// one extra cycle, same read count
	a_cmp_gen_mode1: assert property (
		s_req(itm_pkg::CLASS_DST_COMP, 3'h1, 3'h0) |=> addrCycles == 4'h3 && addrReads == 2'h1)
		else $error("compare mode 1 cost wrong");
	a_cmp_pc_mode2: assert property (
		s_req(itm_pkg::CLASS_DST_COMP, 3'h2, 3'h7) |=> addrCycles == 4'h2 && addrReads == 2'h1)
		else $error("compare pc mode 2 cost wrong");
	a_cmp_pc_mode4: assert property (
		s_req(itm_pkg::CLASS_DST_COMP, 3'h4, 3'h7) |=> addrCycles == 4'h8 && addrReads == 2'h2)
		else $error("compare pc mode 4 cost wrong");

	// ---------------------------------------------------------------
	// totals, write bound and clear
	// ---------------------------------------------------------------
	// maximum side of the range, write time with miss penalty, clear of times
	a_max_sum: assert property (
		opValid && !syncClear && !mainMemory && !writeFlag
		|=> totalMaxCycles == {2'h0, $past(execMaxCycles)} + {4'h0, addrCycles})
		else $error("maximum total is not exec plus address time");
	a_write_add: assert property (
		opValid && !syncClear && writeFlag && mainMemory
		|=> totalMinCycles == {2'h0, $past(execMinCycles)} + {4'h0, addrCycles}
		    + {5'h0, addrReads, 1'b0} + {4'h0, $past(writeCycles)})
		else $error("write time or main memory penalty missing");
	a_no_write_bound: assert property (
		opValid && !syncClear && !writeFlag |=> !lowerBound)
		else $error("read entry marked lower bound");
	a_clear_ns_zero: assert property (
		syncClear |=> totalMinNs == 17'h00000 && totalMaxNs == 17'h00000 && totalMinCycles == 8'h00)
		else $error("synchronous clear left times set");

endmodule
`default_nettype wire

/* File: dv/itm_decoder_model.sv */
`timescale 1ns/1ps
`default_nettype none
// decoder stand-in: one operand request per call, one cycle wide
module itm_decoder_model (
	input  wire logic       core_clk,
	output logic            opValid,
	output logic      [1:0] opClass,
	output logic      [2:0] addrMode,
	output logic      [2:0] regField
);
	initial begin
		opValid = 1'b0;
		opClass = 2'h0;
		addrMode = 3'h0;
		regField = 3'h0;
	end

	// launch just after an edge, hold until the taking edge
	task automatic issue(input logic [1:0] c, input logic [2:0] m, input logic [2:0] r);
		@(posedge core_clk);
		#1;
		opClass = c;
		addrMode = m;
		regField = r;
		opValid = 1'b1;
		@(posedge core_clk);
		#1;
		opValid = 1'b0;
		addrMode = ~m; // stale mode and register fields scrambled once released, class kept
		regField = ~r;
	endtask
endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        core_clk, rstn, syncClear, mainMemory, writeFlag, lowerBound;
	logic        opValid;
	logic [1:0]  opClass, addrReads;
	logic [2:0]  addrMode, regField;
	logic [3:0]  writeCycles, addrCycles;
	logic [5:0]  execMinCycles, execMaxCycles;
	logic [7:0]  totalMinCycles, totalMaxCycles;
	logic [16:0] totalMinNs, totalMaxNs;
	int          n_mismatch = 0;
	int          compares = 0;

	itm_decoder_model dec (.core_clk(core_clk), .opValid(opValid), .opClass(opClass),
		.addrMode(addrMode), .regField(regField));
	itm_timing_model uut (.core_clk(core_clk), .rstn(rstn), .syncClear(syncClear),
		.opValid(opValid), .opClass(opClass), .addrMode(addrMode), .regField(regField),
		.mainMemory(mainMemory), .writeFlag(writeFlag), .writeCycles(writeCycles),
		.execMinCycles(execMinCycles), .execMaxCycles(execMaxCycles),
		.addrCycles(addrCycles), .addrReads(addrReads), .totalMinCycles(totalMinCycles),
		.totalMaxCycles(totalMaxCycles), .totalMinNs(totalMinNs), .totalMaxNs(totalMaxNs),
		.lowerBound(lowerBound));

	// ---------------------------------------------------------------
	// clock, checks, closing
	// ---------------------------------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	task automatic chk(input logic [16:0] got, input logic [16:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wrap_up;
		$display("mismatches %0d, comparisons %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// reference address cost from the timing tables
	task automatic ref_cost(input int c, m, r, output int k, n);
		int g[8] = '{0, 2, 2, 4, 3, 5, 4, 6};
		int q[8] = '{0, 1, 1, 2, 1, 2, 2, 3};
		int p[4] = '{1, 3, 6, 8};
		k = g[m];
		n = q[m] + ((r == 7 && (m == 4 || m == 5)) ? 1 : 0);
		if (r == 7 && m >= 2 && m <= 5) k = p[m - 2] + ((c != 0 && m >= 4) ? 1 : 0);
		if (c == 2 && m != 0) k++;
	endtask

	// one request, then all outputs against the formula
	task automatic run(input int c, m, r, emin, emax);
		int k, n, x;
		ref_cost(c, m, r, k, n);
		execMinCycles = 6'(emin);
		execMaxCycles = 6'(emax);
		dec.issue(2'(c), 3'(m), 3'(r));
		x = k + (mainMemory ? 2 * n : 0) + (writeFlag ? int'(writeCycles) : 0);
		chk(17'(addrCycles), 17'(k));
		chk(17'(addrReads), 17'(n));
		chk(17'(totalMinCycles), 17'(emin + x));
		chk(17'(totalMaxCycles), 17'(emax + x));
		chk(totalMinNs, 17'((emin + x) * 267));
		chk(totalMaxNs, 17'((emax + x) * 267));
		chk(17'(lowerBound), 17'(writeFlag));
	endtask

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_sweep;
		for (int c = 0; c < 4; c++) begin
			for (int m = 0; m < 8; m++) begin
				run(c, m, 0, 1, 1);
				run(c, m, 7, 1, 1);
			end
		end
		run(0, 3, 1, 1, 1);
	endtask

	task automatic t_memwrite;
		mainMemory = 1'b1;
		writeFlag = 1'b1;
		writeCycles = 4'hf;
		run(2, 7, 7, 63, 63);
		writeFlag = 1'b0;
		run(1, 5, 7, 1, 1);
		mainMemory = 1'b0;
	endtask

	task automatic t_range;
		run(0, 5, 7, 2, 40);
		chk(17'(totalMaxCycles), 17'h00030);
	endtask

	task automatic t_hold;
		repeat (3) @(posedge core_clk);
		#1;
		chk(17'(totalMaxCycles), 17'h00030);
		syncClear = 1'b1;
		dec.issue(2'h0, 3'h7, 3'h7);
		chk(17'(addrCycles), 17'h00000);
		chk(totalMinNs, 17'h00000);
		chk(totalMaxNs, 17'h00000);
		syncClear = 1'b0;
	endtask

	initial begin
		rstn = 1'b0;
		syncClear = 1'b0;
		mainMemory = 1'b0;
		writeFlag = 1'b0;
		writeCycles = 4'h0;
		execMinCycles = 6'h01;
		execMaxCycles = 6'h01;
		repeat (10) @(posedge core_clk);
		#1;
		rstn = 1'b1;
		chk(17'(totalMaxCycles), 17'h00000);
		t_sweep();
		t_memwrite();
		t_range();
		t_hold();
		wrap_up();
	end

	// watchdog: the 69 requests fit well inside this
	initial begin
		repeat (5000) @(posedge core_clk);
		n_mismatch++;
		wrap_up();
	end
endmodule
`default_nettype wire
